//--- common/tws_cfg.svh
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define TWS_OFS_CTRL   8'h00
`define TWS_OFS_DATA   8'h04
`define TWS_OFS_STAT   8'h08
`define TWS_OFS_FIFO   8'h0c

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define TWS_CTRL_FLAG  7
`define TWS_CTRL_START 5
`define TWS_CTRL_STOP  4
`define TWS_CTRL_EN    2
`define TWS_CTRL_IE    0

// ------------------------------------------------------------
// status codes, low three bits stay free, the low two carry the prescaler
// ------------------------------------------------------------
`define TWS_ST_START     8'h10
`define TWS_ST_ADDR_ACK  8'h20
`define TWS_ST_ADDR_NACK 8'h28
`define TWS_ST_DATA_ACK  8'h30
`define TWS_ST_DATA_NACK 8'h38
`define TWS_ST_NONE      8'hf8
`define TWS_PRESC_W      2

// ------------------------------------------------------------
// timing and sizes
// ------------------------------------------------------------
`define TWS_CLK_NS     20
`define TWS_BIT_NS     10000
`define TWS_QTR_CYC    (`TWS_BIT_NS / (4 * `TWS_CLK_NS))
`define TWS_FIFO_DEPTH 16
`define TWS_ACK_BIT    8

`endif

//--- common/tws_pkg.sv
package tws_pkg;

  // bus action handed to the bit engine
  typedef enum logic [1:0] {CMD_NONE, CMD_START, CMD_BYTE, CMD_STOP} tws_cmd_t;

  typedef struct packed {
    tws_cmd_t   cmd;
    logic [7:0] data;
  } tws_req_t;

  typedef struct packed {
    logic done;
    logic ack;
  } tws_rsp_t;

  // wire levels: high means pulled low by us
  typedef struct packed {
    logic scl_low;
    logic sda_low;
  } tws_pins_t;

  typedef enum {ST_IDLE, ST_RUN, ST_HOLD} tws_ctl_st_t;
  typedef enum {E_IDLE, E_START, E_BIT, E_STOP} tws_eng_st_t;

endpackage : tws_pkg

//--- logic/tws_ctrl.sv
// Overview of operation
// - every finished START, address or data byte raises the completion flag, and the interrupt when enabled
// - interrupt only when flag, enable bit and global enable all high
// - from the cycle after the flag rises, status holds the bus event code
// - writing one to the flag clears it, writing zero keeps it
// - no bus action starts while the flag stays set
// - a clearing write asking START with the enable bit set launches START at once when the engine is not running
// - START done sets flag and loads the START-sent code
// - one shift register carries address and data bytes
// - address done sets flag, code tells acknowledge or not
// - data done sets flag, code tells the acknowledge received
// - STOP is sent on request and never sets the flag
// - serial clock held low while the flag is set
// - a clearing write with the enable bit set performs the operation its value asks; STOP or a byte only while holding after an event
// - status takes the event code one cycle after the flag
// - without the flag, status reads the no-information code
`timescale 1ns/1ns
`include "tws_cfg.svh"
module tws_ctrl #(
  parameter int QTR_CYC    = `TWS_QTR_CYC,
  parameter int FIFO_DEPTH = `TWS_FIFO_DEPTH
) (
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       GLOBAL_IE_I,
  output logic            IRQ_O,
  input  wire logic       SCL_I,
  output logic            SCL_O,
  output logic            SCL_OE_O,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O
);
  import tws_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    tws_ctl_st_t          st;
    tws_cmd_t             op;          // action now on the wire
    tws_req_t             req;         // one-cycle request to engine
    logic                 flag;        // operation complete
    logic                 start;
    logic                 stop;
    logic                 en;
    logic                 irq_enable_bit;
    logic                 addr_next;   // next byte is an address
    logic [7:0]           pend;        // code caught with the flag
    logic [7:0]           status;      // code shown to software
    logic [`TWS_PRESC_W-1:0] presc;
    logic [7:0]           shift_data_reg;
    logic [7:0]           rdata;
  } tws_ctl_t;

  tws_ctl_t  r;
  tws_ctl_t  next_r;

  // ------------------------------------------------------------
  // links to the submodules
  // ------------------------------------------------------------
  tws_rsp_t  eng_rsp;
  tws_pins_t eng_pins;
  logic      fifo_in_valid;
  logic      fifo_in_ready;
  logic      fifo_out_valid;
  logic      fifo_pop;
  logic [7:0] fifo_data;

  // ------------------------------------------------------------
  // decoded bus strobes
  // ------------------------------------------------------------
  logic      wr_ctrl;
  logic      wr_stat;
  logic      clearing;
  logic      launch_ok;

  assign wr_ctrl  = WR_I && (ADDR_I == `TWS_OFS_CTRL);
  assign wr_stat  = WR_I && (ADDR_I == `TWS_OFS_STAT);
  // a write with the flag bit at one is the only way to go on
  assign clearing = wr_ctrl && WDATA_I[`TWS_CTRL_FLAG];
  // a write of a new byte while the engine runs would be lost,
  // so data writes go through the buffer and wait there
  assign fifo_in_valid = WR_I && (ADDR_I == `TWS_OFS_DATA);
  // launching needs the unit enabled and the engine free
  assign launch_ok = clearing && WDATA_I[`TWS_CTRL_EN]
                     && (r.st != ST_RUN);

  // ------------------------------------------------------------
  // transmit byte buffer
  // ------------------------------------------------------------
  tws_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RST_N_I),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (WDATA_I),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // ------------------------------------------------------------
  // bit engine on the two wires
  // ------------------------------------------------------------
  tws_engine #(
    .QTR_CYC (QTR_CYC)
  ) u_engine (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .req_i   (r.req),
    .rsp_o   (eng_rsp),
    .pins_o  (eng_pins),
    .scl_i   (SCL_I),
    .sda_i   (SDA_I)
  );

  // the buffer drains only when a byte goes out, so it can fill
  assign fifo_pop = launch_ok && !WDATA_I[`TWS_CTRL_START]
                    && !WDATA_I[`TWS_CTRL_STOP]
                    && (r.st == ST_HOLD) && fifo_out_valid;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_r         = r;
    next_r.req.cmd = CMD_NONE;

    // control bits take whatever software wrote
    if (wr_ctrl) begin
      next_r.start          = WDATA_I[`TWS_CTRL_START];
      next_r.stop           = WDATA_I[`TWS_CTRL_STOP];
      next_r.en             = WDATA_I[`TWS_CTRL_EN];
      next_r.irq_enable_bit = WDATA_I[`TWS_CTRL_IE];
    end
    if (wr_stat)
      next_r.presc = WDATA_I[`TWS_PRESC_W-1:0];

    // the written value picks the action; only a clearing write
    // may launch, so nothing moves while the flag is held
    if (launch_ok) begin
      if (WDATA_I[`TWS_CTRL_START]) begin
        next_r.req.cmd = CMD_START;
        next_r.op      = CMD_START;
        next_r.st      = ST_RUN;
      end else if (r.st == ST_HOLD && WDATA_I[`TWS_CTRL_STOP]) begin
        next_r.req.cmd = CMD_STOP;
        next_r.op      = CMD_STOP;
        next_r.st      = ST_RUN;
      end else if (r.st == ST_HOLD) begin
        // address and data share the one shift register
        if (fifo_out_valid)
          next_r.shift_data_reg = fifo_data;
        next_r.req.cmd  = CMD_BYTE;
        next_r.req.data = fifo_out_valid ? fifo_data
                                         : r.shift_data_reg;
        next_r.op       = CMD_BYTE;
        next_r.st       = ST_RUN;
      end
    end

    // engine finished: set beats clear in the same cycle
    if (eng_rsp.done && r.op != CMD_STOP) begin
      next_r.flag = 1'b1;
      next_r.st   = ST_HOLD;
      if (r.op == CMD_START) begin
        next_r.pend      = `TWS_ST_START;
        next_r.addr_next = 1'b1;
      end else if (r.addr_next) begin
        next_r.pend      = eng_rsp.ack ? `TWS_ST_ADDR_ACK
                                       : `TWS_ST_ADDR_NACK;
        next_r.addr_next = 1'b0;
      end else begin
        next_r.pend      = eng_rsp.ack ? `TWS_ST_DATA_ACK
                                       : `TWS_ST_DATA_NACK;
      end
    end else if (eng_rsp.done) begin
      // stop is over: bus free, flag stays down
      next_r.st   = ST_IDLE;
      next_r.op   = CMD_NONE;
    end else if (clearing) begin
      next_r.flag = 1'b0;
    end

    // status trails the flag by one cycle
    next_r.status = r.flag ? r.pend : `TWS_ST_NONE;

    // read data valid only in the cycle after the strobe
    next_r.rdata = '0;
    if (RD_I) begin
      unique case (ADDR_I)
        `TWS_OFS_CTRL: begin
          next_r.rdata[`TWS_CTRL_FLAG]  = r.flag;
          next_r.rdata[`TWS_CTRL_START] = r.start;
          next_r.rdata[`TWS_CTRL_STOP]  = r.stop;
          next_r.rdata[`TWS_CTRL_EN]    = r.en;
          next_r.rdata[`TWS_CTRL_IE]    = r.irq_enable_bit;
        end
        `TWS_OFS_DATA: next_r.rdata = r.shift_data_reg;
        `TWS_OFS_STAT: next_r.rdata = {r.status[7:`TWS_PRESC_W],
                                       r.presc};
        `TWS_OFS_FIFO: next_r.rdata = {6'h00, fifo_out_valid,
                                       !fifo_in_ready};
        default:       next_r.rdata = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      r        <= '0;
      r.st     <= ST_IDLE;
      r.op     <= CMD_NONE;
      r.req    <= '{cmd: CMD_NONE, data: 8'h00};
      r.status <= `TWS_ST_NONE;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // interrupt needs the local enable and the cpu_flags_reg enable
  assign IRQ_O    = r.flag && r.irq_enable_bit && GLOBAL_IE_I;
  assign RDATA_O  = r.rdata;
  // open drain: a line is only ever pulled low
  assign SCL_O    = 1'b0;
  assign SDA_O    = 1'b0;
  // clock held low so software has time before the next cycle
  assign SCL_OE_O = eng_pins.scl_low || r.flag;
  assign SDA_OE_O = eng_pins.sda_low;

endmodule : tws_ctrl

//--- logic/tws_engine.sv
`timescale 1ns/1ns
`include "tws_cfg.svh"
module tws_engine #(
  parameter int QTR_CYC = `TWS_QTR_CYC
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire tws_pkg::tws_req_t req_i,
  output tws_pkg::tws_rsp_t  rsp_o,
  output tws_pkg::tws_pins_t pins_o,
  input  wire logic          scl_i,
  input  wire logic          sda_i
);
  import tws_pkg::*;

  typedef struct packed {
    tws_eng_st_t st;
    logic [15:0] cnt;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [8:0]  sh;
    tws_pins_t   pins;
    tws_rsp_t    rsp;
  } tws_eng_t;

  tws_eng_t r;
  tws_eng_t next_r;
  logic     tick;

  // a phase ends after a quarter bit; a slave may stretch the high phase
  assign tick = (r.cnt == 16'(QTR_CYC - 1)) && (r.ph != 2'd2 || scl_i);
  assign rsp_o  = r.rsp;
  assign pins_o = r.pins;

  // ------------------------------------------------------------
  // bit sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_r          = r;
    next_r.rsp.done = 1'b0;
    // the count parks at the phase end while a slave stretches the
    // clock, so a long stretch can never run past the match
    if (r.st != E_IDLE)
      next_r.cnt = tick ? '0
                 : (r.cnt == 16'(QTR_CYC - 1)) ? r.cnt
                 : r.cnt + 16'd1;
    unique case (r.st)
      E_IDLE: begin
        next_r.ph  = '0;
        next_r.cnt = '0;
        unique case (req_i.cmd)
          CMD_START: begin
            next_r.st   = E_START;
            next_r.pins = '0;            // both lines released first
          end
          CMD_BYTE: begin
            next_r.st   = E_BIT;
            next_r.sh   = {req_i.data, 1'b1};
            next_r.bitn = '0;
          end
          CMD_STOP: begin
            next_r.st   = E_STOP;
            next_r.pins = '{scl_low: 1'b1, sda_low: 1'b1};
          end
          CMD_NONE: ;
        endcase
      end
      E_START: if (tick) begin
        next_r.ph = r.ph + 2'd1;
        if (r.ph == 2'd1) next_r.pins.sda_low = 1'b1;
        if (r.ph == 2'd2) begin
          next_r.pins.scl_low = 1'b1;
          next_r.rsp.done     = 1'b1;
          next_r.st           = E_IDLE;
        end
      end
      E_BIT: if (tick) begin
        next_r.ph = r.ph + 2'd1;
        unique case (r.ph)
          2'd0: next_r.pins.sda_low = !r.sh[8];
          2'd1: next_r.pins.scl_low = 1'b0;
          2'd2: if (r.bitn == 4'(`TWS_ACK_BIT)) next_r.rsp.ack = !sda_i;
          2'd3: begin
            next_r.pins.scl_low = 1'b1;
            next_r.sh           = {r.sh[7:0], 1'b0};
            next_r.bitn         = r.bitn + 4'd1;
            if (r.bitn == 4'(`TWS_ACK_BIT)) begin
              next_r.rsp.done = 1'b1;
              next_r.st       = E_IDLE;
            end
          end
        endcase
      end
      E_STOP: if (tick) begin
        next_r.ph = r.ph + 2'd1;
        if (r.ph == 2'd0) next_r.pins.scl_low = 1'b0;
        if (r.ph == 2'd1) begin
          next_r.pins.sda_low = 1'b0;
          next_r.rsp.done     = 1'b1;
          next_r.st           = E_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r    <= '0;
      r.st <= E_IDLE;
    end else begin
      r <= next_r;
    end
  end
endmodule : tws_engine

//--- logic/tws_fifo.sv
`timescale 1ns/1ns
module tws_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } tws_fifo_t;

  tws_fifo_t    r;
  tws_fifo_t    next_r;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;

  // honest flags straight from the count
  assign in_ready_o  = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o  = mem[r.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_r = r;
    if (push) next_r.wp = r.wp + 1'b1;
    if (pop)  next_r.rp = r.rp + 1'b1;
    next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) r <= '0;
    else          r <= next_r;
  end

  // storage needs no reset, pointers guard it
  always_ff @(posedge clk_i) begin
    if (push) mem[r.wp] <= in_data_i;
  end
endmodule : tws_fifo

//--- verif/tb.sv
`timescale 1ns/1ns
`include "tws_cfg.svh"
module tb;
  logic       clk, rst_n, wr, rd, gie, nack, stb;
  logic       irq, scl_o, scl_oe, sda_o, sda_oe, scl_low, sda_low;
  logic [7:0] addr, wdata, rdata, sbyte, v, e;
  logic [3:0] stretch;
  logic [7:0] exp_q[$], got_q[$];
  int         n_mismatch, n_compared, seed, k;
  // wired-and with pull-ups on both lines
  wire        scl_w = !(scl_oe || scl_low);
  wire        sda_w = !(sda_oe || sda_low);

  tws_ctrl #(.QTR_CYC(2), .FIFO_DEPTH(16)) i_dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .GLOBAL_IE_I(gie), .IRQ_O(irq),
    .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe));
  tws_slave_model i_slave (.clk_i(clk), .scl_i(scl_w), .sda_i(sda_w),
    .nack_i(nack), .stretch_i(stretch), .scl_low_o(scl_low),
    .sda_low_o(sda_low), .byte_o(sbyte), .byte_stb_o(stb));

  // ----------------------------------------------------------
  // clock, capture, watchdog
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (stb === 1'b1) got_q.push_back(sbyte);
  // a full run needs a few thousand cycles, so this only cuts a hang
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    $display("mismatch watchdog expected end seen hang");
    tally_and_finish();
  end

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  // poll for the flag, then look at request and clock hold
  task automatic wait_flag(input logic ir);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 400 && c[7] !== 1'b1; i++) rd_reg(8'h00, c);
    chk("flag", 8'h01, {7'h00, c[7]});
    chk("irq", {7'h00, ir}, {7'h00, irq});
    chk("scl_hold", 8'h01, {7'h00, scl_oe});
  endtask : wait_flag
  // one control write, then status and the byte the slave saw
  task automatic launch(input logic [7:0] c, input logic [7:0] st,
                        input logic ir);
    logic [7:0] s, g;
    wr_reg(`TWS_OFS_CTRL, c);
    wait_flag(ir);
    rd_reg(`TWS_OFS_STAT, s);
    chk("status", st, s & 8'hf8);
    if (c[`TWS_CTRL_START] == 1'b0) begin
      g = (got_q.size() > 0) ? got_q.pop_front() : 8'hxx;
      chk("byte", exp_q.pop_front(), g);
    end
  endtask : launch
  task automatic idle_check(input logic [7:0] st);
    repeat (40) @(posedge clk);
    rd_reg(`TWS_OFS_CTRL, v);
    chk("flag_low", 8'h00, {7'h00, v[7]});
    rd_reg(`TWS_OFS_STAT, v);
    chk("status_none", st, v & 8'hf8);
  endtask : idle_check
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    {rst_n, wr, rd, addr, wdata, nack, stretch} = '0;
    {n_mismatch, n_compared} = '0;
    gie = 1'b1;
    seed = 32'h86dd7661;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    idle_check(8'hf8);
    rd_reg(`TWS_OFS_FIFO, v);
    chk("fifo_empty", 8'h00, v);
    rd_reg(8'h10, v);
    chk("unmapped", 8'h00, v);
    wr_reg(`TWS_OFS_STAT, 8'h03);
    rd_reg(`TWS_OFS_STAT, v);
    chk("presc", `TWS_ST_NONE | 8'h03, v);
    $display("test reset done");
    // start, address, sixteen buffered bytes, last one refused by slave
    launch(8'ha5, `TWS_ST_START, 1'b1);
    v = 8'($random(seed)) & 8'hfe;
    wr_reg(`TWS_OFS_DATA, v);
    exp_q.push_back(v);
    launch(8'h85, `TWS_ST_ADDR_ACK, 1'b1);
    e = v;
    rd_reg(`TWS_OFS_DATA, v);
    chk("data_reg", e, v);
    for (k = 0; k < 17; k++) begin
      v = 8'($random(seed));
      wr_reg(`TWS_OFS_DATA, v);
      if (k < 16) exp_q.push_back(v);
    end
    rd_reg(`TWS_OFS_FIFO, v);
    chk("fifo_full", 8'h03, v);
    for (k = 0; k < 16; k++) begin
      nack = (k == 15);
      stretch = 4'($random(seed)) & 4'h7;
      launch(8'h85, nack ? `TWS_ST_DATA_NACK : `TWS_ST_DATA_ACK, 1'b1);
    end
    rd_reg(`TWS_OFS_FIFO, v);
    chk("fifo_drained", 8'h00, v);
    wr_reg(`TWS_OFS_CTRL, 8'h95);
    idle_check(8'hf8);
    chk("lines_free", 8'h00, {4'h0, scl_o, sda_o, scl_oe, sda_oe});
    $display("test transfer done");
    // polled run without global enable, address refused
    @(posedge clk);
    gie <= 1'b0;
    launch(8'ha5, `TWS_ST_START, 1'b0);
    v = 8'($random(seed)) & 8'hfe;
    wr_reg(`TWS_OFS_DATA, v);
    exp_q.push_back(v);
    launch(8'h85, `TWS_ST_ADDR_NACK, 1'b0);
    // global enable back on so a kept flag shows as a standing request
    @(posedge clk);
    gie <= 1'b1;
    wr_reg(`TWS_OFS_CTRL, 8'h05);
    rd_reg(`TWS_OFS_CTRL, v);
    chk("flag_kept", 8'h01, {7'h00, v[7]});
    chk("irq_kept", 8'h01, {7'h00, irq});
    wr_reg(`TWS_OFS_CTRL, 8'h81);
    idle_check(8'hf8);
    nack = 1'b0;
    launch(8'ha5, `TWS_ST_START, 1'b1);
    wr_reg(`TWS_OFS_CTRL, 8'h95);
    idle_check(8'hf8);
    chk("lines_free2", 8'h00, {4'h0, scl_o, sda_o, scl_oe, sda_oe});
    chk("bytes_left", 8'h00, 8'(got_q.size()));
    $display("test polled done");
    tally_and_finish();
  end
endmodule : tb

bind tws_ctrl tws_ctrl_props #(.QTR_CYC(QTR_CYC), .FIFO_DEPTH(FIFO_DEPTH))
  i_props (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .GLOBAL_IE_I(GLOBAL_IE_I), .IRQ_O(IRQ_O), .SCL_I(SCL_I), .SCL_O(SCL_O),
  .SCL_OE_O(SCL_OE_O), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O));

//--- verif/tws_ctrl_properties.sv
`timescale 1ns/1ns
`include "tws_cfg.svh"
module tws_ctrl_props #(
  parameter int QTR_CYC    = 2,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic       CORE_CLK_I,
  input wire logic       RST_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       GLOBAL_IE_I,
  input wire logic       IRQ_O,
  input wire logic       SCL_I,
  input wire logic       SCL_O,
  input wire logic       SCL_OE_O,
  input wire logic       SDA_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_O
);
  localparam int START_MAX = 3 * QTR_CYC + 4;
  logic ie;
  wire  ctrl_wr = WR_I && (ADDR_I == `TWS_OFS_CTRL);
  wire  bus_idle = !SCL_OE_O && !SDA_OE_O;

  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // shadow of the enable bit, the flag itself is not visible here
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) ie <= 1'b0;
    else if (ctrl_wr) ie <= WDATA_I[`TWS_CTRL_IE];
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  irq_global_a: assert property (IRQ_O |-> GLOBAL_IE_I)
    else $error("request without global enable");
  irq_enable_a: assert property (IRQ_O |-> ie)
    else $error("request without enable bit");
  flag_clear_a: assert property (
    ctrl_wr && WDATA_I[`TWS_CTRL_FLAG] && IRQ_O |=> !IRQ_O)
    else $error("writing one did not clear flag");
  flag_keep_a: assert property (
    ctrl_wr && !WDATA_I[`TWS_CTRL_FLAG] && WDATA_I[`TWS_CTRL_IE] && IRQ_O
    ##1 GLOBAL_IE_I |-> IRQ_O)
    else $error("writing zero cleared flag");
  scl_held_a: assert property (IRQ_O && $past(IRQ_O) |-> SCL_OE_O)
    else $error("serial clock released while flag set");
  no_action_a: assert property (
    IRQ_O && $past(IRQ_O, 2) |-> $stable(SDA_OE_O))
    else $error("data line moved while flag set");
  start_go_a: assert property (
    ctrl_wr && WDATA_I[`TWS_CTRL_FLAG] && WDATA_I[`TWS_CTRL_START]
    && WDATA_I[`TWS_CTRL_EN] && bus_idle |-> ##[1:START_MAX] SDA_OE_O)
    else $error("start not launched in time");
  open_drain_a: assert property (!SCL_O && !SDA_O)
    else $error("pin driven high");
  rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside its cycle");

  // main scenarios reached
  cover property ($rose(IRQ_O));
  cover property (ctrl_wr && WDATA_I[`TWS_CTRL_START] && bus_idle);
  cover property (RD_I && ADDR_I == `TWS_OFS_STAT);
endmodule : tws_ctrl_props

//--- verif/tws_slave_model.sv
`timescale 1ns/1ns
module tws_slave_model (
  input  wire logic       clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       nack_i,
  input  wire logic [3:0] stretch_i,
  output logic            scl_low_o,
  output logic            sda_low_o,
  output logic [7:0]      byte_o,
  output logic            byte_stb_o
);
  logic       scl_q, sda_q;
  logic [7:0] sh;
  int         bitn, hold;

  initial begin
    {scl_q, sda_q} = 2'b11;
    {sh, bitn, hold} = '0;
    {scl_low_o, sda_low_o, byte_o, byte_stb_o} = '0;
  end

  // sampled receiver: start resets the count, ack on the ninth bit
  always @(posedge clk_i) begin
    byte_stb_o <= 1'b0;
    if (scl_q && scl_i && sda_q && !sda_i) begin
      bitn = 0;
    end else if (!scl_q && scl_i) begin
      if (bitn < 8) sh = {sh[6:0], sda_i};
      bitn = bitn + 1;
      if (bitn == 8) begin
        byte_o <= sh;
        byte_stb_o <= 1'b1;
      end
    end else if (scl_q && !scl_i) begin
      // released line goes back to the pull-up, not the old level
      sda_low_o <= (bitn == 8) && !nack_i;
      if (bitn == 9) bitn = 0;
      hold = stretch_i;
    end
    // slow slave: keeps the clock low a few cycles after each fall
    scl_low_o <= (hold > 0);
    if (hold > 0) hold = hold - 1;
    scl_q = scl_i;
    sda_q = sda_i;
  end
endmodule : tws_slave_model
